// *** hw/csc_map.svh ***
// register offsets, field positions and reset values of the command source combiner
`ifndef CSC_MAP_SVH
`define CSC_MAP_SVH

// byte offsets of the register words
`define CSC_OFS_SEL          4'h0
`define CSC_OFS_SER          4'h4
`define CSC_OFS_STAT         4'h8

// source selector word fields
`define CSC_SEL_DIR_LSB      0
`define CSC_SEL_SETUP_LSB    2
`define CSC_SEL_PRESET_LSB   4
`define CSC_SEL_W            6

// serial command word fields
`define CSC_SER_REV_BIT      0
`define CSC_SER_SETUP_LSB    1
`define CSC_SER_PRESET_LSB   3
`define CSC_SER_W            5

// status word fields
`define CSC_STAT_CCW_BIT     0
`define CSC_STAT_SETUP_LSB   1
`define CSC_STAT_PRESET_LSB  3
`define CSC_STAT_TREV_BIT    5
`define CSC_STAT_TSETUP_LSB  6
`define CSC_STAT_TPRESET_LSB 8
`define CSC_STAT_W           10

// reset values
`define CSC_SEL_RST          6'h00
`define CSC_SER_RST          5'h00
`define CSC_IDX_RST          2'h0
`define CSC_ONEHOT_RST       4'h1

`endif

// *** hw/csc_pkg.sv ***
// types shared by the command source combiner files
package csc_pkg;

    // combining mode of one source selector
    typedef enum logic [1:0]
    {
        CSC_TERM = 2'b00,
        CSC_SER  = 2'b01,
        CSC_AND  = 2'b10,
        CSC_OR   = 2'b11
    } csc_mode_t;

    // the three independent source selectors
    typedef struct packed
    {
        csc_mode_t preset;
        csc_mode_t setup;
        csc_mode_t dir;
    } csc_sel_t;

    // command bits, as held by the terminals or by the serial word
    typedef struct packed
    {
        logic [1:0] preset;
        logic [1:0] setup;
        logic       rev;
    } csc_cmd_t;

endpackage

// *** hw/csc_combine.sv ***
// four-way terminal/serial combiner for one command field
`timescale 1ns/10ps
module csc_combine #(
    parameter int W = 2
) (
    // selector
    input  wire csc_pkg::csc_mode_t mode_in,
    // the two sources
    input  wire logic [W-1:0]       term_in,
    input  wire logic [W-1:0]       ser_in,
    // combined value
    output logic      [W-1:0]       comb_out
);
    import csc_pkg::*;

    // pure selection; the caller registers the result
    always_comb
    begin
        unique case (mode_in)
            CSC_TERM: comb_out = term_in;           // serial ignored
            CSC_SER:  comb_out = ser_in;            // terminals ignored
            CSC_AND:  comb_out = term_in & ser_in;  // both must agree
            CSC_OR:   comb_out = term_in | ser_in;  // either source
        endcase
    end
endmodule

// *** hw/csc_top.sv ***
// command source combiner: direction, setup and preset selection with an avalon-mm register slave
//
// Functional notes
// [R1] code 0: direction follows reverse terminal only
// [R2] code 1: direction follows serial reverse only
// [R3] code 2: reverse needs terminal and serial
// [R4] code 3: reverse on terminal or serial
// [R5] setup number is one plus combined pair
// [R6] preset number uses own independent selector
// [R7] master writes numeric selector codes 0..3
// [R8] setup number picks the active stored setup
// [R9] each command selects terminal, serial or both
// [R10] outputs registered; reset gives clockwise, 1, 1
`timescale 1ns/10ps
`include "csc_map.svh"
module csc_top #(
    parameter int ADDR_W = 4,
    parameter int NSETUP = 4
) (
    // clock and reset
    input  wire logic                  core_clk_in,
    input  wire logic                  reset_in,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0]     avs_address_in,
    input  wire logic                  avs_read_in,
    input  wire logic                  avs_write_in,
    input  wire logic [31:0]           avs_writedata_in,
    input  wire logic [3:0]            avs_byteenable_in,
    output logic      [31:0]           avs_readdata_out,
    output logic                       avs_waitrequest_out,
    // digital input terminals
    input  wire csc_pkg::csc_cmd_t     term_in,
    // combined commands
    output logic                       dir_ccw_out,
    output logic      [1:0]            setup_idx_out,
    output logic      [1:0]            preset_idx_out,
    output logic      [NSETUP-1:0]     setup_active_out
);
    import csc_pkg::*;

    // ****************************************
    // register slave
    // ****************************************

    csc_sel_t    sel_ff;          // source selectors
    csc_sel_t    nxt_sel;
    csc_cmd_t    ser_ff;          // serial command bits
    csc_cmd_t    nxt_ser;
    logic        wait_ff;         // waitrequest, high while idle
    logic        nxt_wait;
    logic [31:0] rdata_ff;        // read data held for the answer cycle
    logic [31:0] nxt_rdata;
    logic        req;             // a read or write is pending
    logic        acc_wr;          // write accepted at this edge
    logic [31:0] stat_word;       // live status for readback

    assign req    = avs_read_in | avs_write_in;
    assign acc_wr = avs_write_in & ~wait_ff;

    // status shows the block's own outputs and the raw terminals
    always_comb
    begin
        stat_word = 32'h0;
        stat_word[`CSC_STAT_CCW_BIT]                     = dir_ccw_out;
        stat_word[`CSC_STAT_SETUP_LSB +: 2]              = setup_idx_out;
        stat_word[`CSC_STAT_PRESET_LSB +: 2]             = preset_idx_out;
        stat_word[`CSC_STAT_TREV_BIT]                    = term_in.rev;
        stat_word[`CSC_STAT_TSETUP_LSB +: 2]             = term_in.setup;
        stat_word[`CSC_STAT_TPRESET_LSB +: 2]            = term_in.preset;
    end

    // one wait cycle per access: the fixed latency keeps the decode trivially timed
    always_comb
    begin
        nxt_wait  = ~(req & wait_ff);
        nxt_rdata = rdata_ff;
        nxt_sel   = sel_ff;
        nxt_ser   = ser_ff;
        if (avs_read_in && wait_ff)
        begin
            // unmapped offsets read as zero
            unique case (avs_address_in)
                `CSC_OFS_SEL:  nxt_rdata = {{(32-`CSC_SEL_W){1'b0}}, sel_ff};
                `CSC_OFS_SER:  nxt_rdata = {{(32-`CSC_SER_W){1'b0}}, ser_ff};
                `CSC_OFS_STAT: nxt_rdata = stat_word;
                default:       nxt_rdata = 32'h0;
            endcase
        end
        // every writable field sits in byte lane 0; other lanes and offsets are ignored
        if (acc_wr && avs_byteenable_in[0])
        begin
            if (avs_address_in == `CSC_OFS_SEL)
            begin
                // the selector takes the numeric code only, 0..3 per field, see [R7] see [R9]
                nxt_sel = csc_sel_t'(avs_writedata_in[`CSC_SEL_W-1:0]);
            end
            if (avs_address_in == `CSC_OFS_SER)
            begin
                nxt_ser = csc_cmd_t'(avs_writedata_in[`CSC_SER_W-1:0]);
            end
        end
    end

    // bus state registers
    always_ff @(posedge core_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0;
            sel_ff   <= csc_sel_t'(`CSC_SEL_RST);
            ser_ff   <= csc_cmd_t'(`CSC_SER_RST);
        end
        else
        begin
            wait_ff  <= nxt_wait;
            rdata_ff <= nxt_rdata;
            sel_ff   <= nxt_sel;
            ser_ff   <= nxt_ser;
        end
    end

    assign avs_waitrequest_out = wait_ff;
    assign avs_readdata_out    = rdata_ff;

    // ****************************************
    // combining logic
    // ****************************************

    logic [0:0]        comb_dir;     // combined reverse request
    logic [1:0]        comb_setup;   // combined setup pair, msb first
    logic [1:0]        comb_preset;  // combined preset pair, msb first
    logic              dir_ff;
    logic [1:0]        setup_ff;
    logic [1:0]        preset_ff;
    logic [NSETUP-1:0] onehot_ff;
    logic [NSETUP-1:0] nxt_onehot;

    // direction: 1 means counter-clockwise, see [R1] see [R2] see [R3] see [R4]
    csc_combine #(.W(1)) u_dir (
        .mode_in  (sel_ff.dir),
        .term_in  (term_in.rev),
        .ser_in   (ser_ff.rev),
        .comb_out (comb_dir)
    );

    // setup pair, index is setup number minus one, see [R5]
    csc_combine #(.W(2)) u_setup (
        .mode_in  (sel_ff.setup),
        .term_in  (term_in.setup),
        .ser_in   (ser_ff.setup),
        .comb_out (comb_setup)
    );

    // preset pair on its own selector, see [R6]
    csc_combine #(.W(2)) u_preset (
        .mode_in  (sel_ff.preset),
        .term_in  (term_in.preset),
        .ser_in   (ser_ff.preset),
        .comb_out (comb_preset)
    );

    // decode of the active setup, one bit per stored setup, see [R8]
    generate
        for (genvar i = 0; i < NSETUP; i++)
        begin : g_onehot
            assign nxt_onehot[i] = (comb_setup == 2'(i));
        end
    endgenerate

    // outputs lag any input one clock so all three change together, see [R10]
    always_ff @(posedge core_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            dir_ff    <= 1'b0;
            setup_ff  <= `CSC_IDX_RST;
            preset_ff <= `CSC_IDX_RST;
            onehot_ff <= NSETUP'(`CSC_ONEHOT_RST);
        end
        else
        begin
            dir_ff    <= comb_dir[0];
            setup_ff  <= comb_setup;
            preset_ff <= comb_preset;
            onehot_ff <= nxt_onehot;
        end
    end

    assign dir_ccw_out      = dir_ff;
    assign setup_idx_out    = setup_ff;
    assign preset_idx_out   = preset_ff;
    assign setup_active_out = onehot_ff;

    // ****************************************
    // checks
    // ****************************************

    logic past_ok_ff;   // previous edge was outside reset

    always_ff @(posedge core_clk_in or posedge reset_in)
    begin
        if (reset_in)
            past_ok_ff <= 1'b0;
        else
            past_ok_ff <= 1'b1;
    end

    // independent model of one combining mode
    function automatic logic [1:0] ref_comb(input logic [1:0] m, input logic [1:0] t, input logic [1:0] s);
        logic [1:0] r;
        r = t;
        if (m == 2'h1)
            r = s;
        if (m == 2'h2)
            r = t & s;
        if (m == 2'h3)
            r = t | s;
        return r;
    endfunction

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    sequence acc_sel_s;
        avs_write_in && !wait_ff && avs_byteenable_in[0] && avs_address_in == `CSC_OFS_SEL;
    endsequence

    dir_term_a: assert property (past_ok_ff && $past(sel_ff.dir) == CSC_TERM |-> dir_ccw_out == $past(term_in.rev)) // see [R1]
        else $error("direction does not follow terminal");
    dir_serial_a: assert property (past_ok_ff && $past(sel_ff.dir) == CSC_SER |-> dir_ccw_out == $past(ser_ff.rev)) // see [R2]
        else $error("direction does not follow serial bit");
    dir_and_a: assert property (past_ok_ff && $past(sel_ff.dir) == CSC_AND // see [R3]
        |-> dir_ccw_out == ($past(term_in.rev) && $past(ser_ff.rev)))
        else $error("direction and mode wrong");
    dir_or_a: assert property (past_ok_ff && $past(sel_ff.dir) == CSC_OR // see [R4]
        |-> dir_ccw_out == ($past(term_in.rev) || $past(ser_ff.rev)))
        else $error("direction or mode wrong");
    setup_comb_a: assert property (past_ok_ff // see [R5]
        |-> setup_idx_out == ref_comb($past(sel_ff.setup), $past(term_in.setup), $past(ser_ff.setup)))
        else $error("setup number wrong");
    preset_comb_a: assert property (past_ok_ff // see [R6]
        |-> preset_idx_out == ref_comb($past(sel_ff.preset), $past(term_in.preset), $past(ser_ff.preset)))
        else $error("preset number wrong");
    active_setup_a: assert property (setup_active_out == (NSETUP'(1) << setup_idx_out)) // see [R8]
        else $error("active setup does not match setup number");
    sel_write_a: assert property (acc_sel_s |=> sel_ff == $past(avs_writedata_in[`CSC_SEL_W-1:0])) // see [R9]
        else $error("selector write lost");
    reset_vals_a: assert property (!past_ok_ff |-> !dir_ccw_out && setup_idx_out == 2'h0 && preset_idx_out == 2'h0) // see [R10]
        else $error("outputs not at reset value");
    bus_answer_a: assert property (req && wait_ff |=> !wait_ff ##1 wait_ff) // see [R10]
        else $error("waitrequest not one cycle");
endmodule

// *** tb/csc_host.sv ***
// avalon-mm master model standing in for the serial communication side
`timescale 1ns/10ps
module csc_host
(
    // clock and slave answer
    input  wire logic        clk_in,
    input  wire logic        waitrequest_in,
    input  wire logic [31:0] readdata_in,
    // request
    output logic      [3:0]  address_out,
    output logic             read_out,
    output logic             write_out,
    output logic      [31:0] writedata_out,
    output logic      [3:0]  byteenable_out
);
    // idle bus from time zero
    initial
    begin
        address_out = 4'h0;
        read_out = 1'b0;
        write_out = 1'b0;
        writedata_out = 32'h0;
        byteenable_out = 4'h0;
    end

    // one write, held until waitrequest is seen low; selector codes go as numbers 0..3
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk_in);
        address_out <= a;
        writedata_out <= d;
        byteenable_out <= be;
        write_out <= 1'b1;
        do @(posedge clk_in); while (waitrequest_in !== 1'b0);
        write_out <= 1'b0;
        // released data is scrambled so nothing leans on a stale value
        writedata_out <= ~d;
    endtask

    // one read; data taken at the same edge that sees waitrequest low
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_in);
        address_out <= a;
        byteenable_out <= 4'hf;
        read_out <= 1'b1;
        do @(posedge clk_in); while (waitrequest_in !== 1'b0);
        d = readdata_in;
        read_out <= 1'b0;
    endtask
endmodule

// *** tb/tb.sv ***
// self-checking bench of the command source combiner
`timescale 1ns/10ps
module tb;
    import csc_pkg::*;
    // one row: selector word, serial word, terminals, expected outputs
    typedef struct packed
    {
        logic [5:0] sel;
        logic [4:0] ser;
        logic [4:0] term;
        logic       ccw;
        logic [1:0] setup;
        logic [1:0] preset;
    } csc_row_t;
    logic        clk, rst, rd, wr, wreq, ccw;
    logic [3:0]  adr, be, act;
    logic [31:0] wd, rdat, d;
    logic [1:0]  setup, preset;
    csc_cmd_t    term;
    int          error_cnt, checked, cyc;
    // every mode of every selector, plus mixed selectors
    csc_row_t    rows [9] = '{
        '{6'h00, 5'h1f, 5'h00, 1'b0, 2'h0, 2'h0}, '{6'h00, 5'h00, 5'h1b, 1'b1, 2'h1, 2'h3},
        '{6'h15, 5'h16, 5'h01, 1'b0, 2'h3, 2'h2}, '{6'h2a, 5'h1b, 5'h0f, 1'b1, 2'h1, 2'h1},
        '{6'h2a, 5'h1b, 5'h16, 1'b0, 2'h1, 2'h2}, '{6'h3f, 5'h0a, 5'h14, 1'b0, 2'h3, 2'h3},
        '{6'h3f, 5'h01, 5'h00, 1'b1, 2'h0, 2'h0}, '{6'h31, 5'h0d, 5'h12, 1'b1, 2'h1, 2'h3},
        '{6'h1b, 5'h1c, 5'h07, 1'b1, 2'h2, 2'h3}};

    csc_top dut_u (.core_clk_in(clk), .reset_in(rst), .avs_address_in(adr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wreq), .term_in(term), .dir_ccw_out(ccw), .setup_idx_out(setup),
        .preset_idx_out(preset), .setup_active_out(act));
    csc_host host_u (.clk_in(clk), .waitrequest_in(wreq), .readdata_in(rdat), .address_out(adr),
        .read_out(rd), .write_out(wr), .writedata_out(wd), .byteenable_out(be));

    // 125 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // compare one value; four-state match only
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // outputs expected while reset is held
    task automatic chk_rst;
        chk("dir", 32'h0, ccw);
        chk("setup", 32'h0, setup);
        chk("preset", 32'h0, preset);
        chk("active", 32'h1, act);
        chk("waitrequest", 32'h1, wreq);
        chk("readdata", 32'h0, rdat);
    endtask

    // verdict and end of run
    task automatic end_sim;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // hang guard: whole run needs about a hundred cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            end_sim();
        end
    end

    initial
    begin
        rst = 1'b1;
        term = '0;
        repeat (2) @(posedge clk);
        #1 chk_rst();
        @(posedge clk);
        rst <= 1'b0;
        // table rows
        foreach (rows[i])
        begin
            host_u.wr(4'h0, {26'h0, rows[i].sel}, 4'hf);
            host_u.wr(4'h4, {27'h0, rows[i].ser}, 4'hf);
            @(posedge clk);
            term <= rows[i].term;
            @(posedge clk);
            #1 chk("dir", rows[i].ccw, ccw);
            chk("setup", rows[i].setup, setup);
            chk("preset", rows[i].preset, preset);
            chk("active", 32'h1 << rows[i].setup, act);
        end
        // status word of the last row, then refused writes
        host_u.rd(4'h8, d);
        chk("status", 32'hfd, d);
        host_u.wr(4'h0, 32'h0, 4'h0);
        host_u.wr(4'h8, 32'h0, 4'hf);
        host_u.rd(4'h0, d);
        chk("sel kept", 32'h1b, d);
        host_u.rd(4'h8, d);
        chk("status kept", 32'hfd, d);
        host_u.rd(4'hc, d);
        chk("unmapped", 32'h0, d);
        // selector write shows one edge after it lands, terminals one edge after they move
        host_u.wr(4'h0, 32'h0, 4'hf);
        @(posedge clk);
        term <= 5'h18;
        #1 chk("dir", 32'h1, ccw);
        chk("active", 32'h8, act);
        chk("preset", 32'h0, preset);
        @(posedge clk);
        #1 chk("dir", 32'h0, ccw);
        chk("active", 32'h1, act);
        chk("preset", 32'h3, preset);
        // second reset in mid-run, terminals still set
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        #1 chk_rst();
        @(posedge clk);
        rst <= 1'b0;
        // first edge after release: outputs follow the terminals again
        @(posedge clk);
        #1 chk("preset", 32'h3, preset);
        chk("dir", 32'h0, ccw);
        // selector and serial words back at their reset values
        host_u.rd(4'h0, d);
        chk("sel reset", 32'h0, d);
        host_u.rd(4'h4, d);
        chk("ser reset", 32'h0, d);
        end_sim();
    end
endmodule
